/* File: branch_notify_pkg.sv */
// Package for the branch capability and hot-plug notify block.
// Assumes a single 100 MHz clock domain and byte-wide register reads.
package branch_notify_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CAPABILITY_REVISION = 8'h00;
    localparam logic [7:0] OFF_PEAK_LANE_RATE      = 8'h01;
    localparam logic [7:0] OFF_PEAK_LANE_TOTAL     = 8'h02;
    localparam logic [7:0] OFF_SPREAD_SUPPORT      = 8'h03;

    // Local capability values after reset
    localparam logic [7:0] RST_CAPABILITY_REVISION = 8'h10;
    localparam logic [4:0] RST_PEAK_LANE_RATE      = 5'h0A;
    localparam logic [3:0] RST_PEAK_LANE_TOTAL     = 4'h4;
    localparam logic       RST_SPREAD_SUPPORT      = 1'b1;

    // Legal codes
    localparam logic [4:0] RATE_LOW  = 5'h06;
    localparam logic [4:0] RATE_HIGH = 5'h0A;
    localparam logic [3:0] LANES_ONE  = 4'h1;
    localparam logic [3:0] LANES_TWO  = 4'h2;
    localparam logic [3:0] LANES_FOUR = 4'h4;

    // Field positions
    localparam int REV_MINOR_LSB = 0;
    localparam int REV_MAJOR_LSB = 4;

    // Timing: low pulse 0.5 ms to 1 ms, aim at 0.75 ms
    localparam int CLK_PERIOD_NS  = 10;
    localparam int HPD_LOW_MIN_US = 500;
    localparam int HPD_LOW_MAX_US = 1000;
    localparam int HPD_LOW_CYCLES =
        ((HPD_LOW_MIN_US + HPD_LOW_MAX_US) / 2) * 1000 / CLK_PERIOD_NS;
    localparam int HPD_CNT_W = 17;

    // Downstream ports and symbol width
    localparam int NUM_DS_PORTS = 4;
    localparam int SYMBOL_W     = 9;
    localparam int LANES_MAX    = 4;

    typedef enum logic [2:0] {
        HPD_HIGH = 3'b001,
        HPD_LOW  = 3'b010,
        HPD_HOLD = 3'b100
    } hpd_state_type;

endpackage

/* File: cap_merge_if.sv */
// Interface carrying local and downstream capabilities into the merge unit.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cap_merge_if;
    logic [7:0] local_rev;
    logic [4:0] local_rate;
    logic [3:0] local_lanes;
    logic       local_spread;
    logic [7:0] ds_rev;
    logic [4:0] ds_rate;
    logic [3:0] ds_lanes;
    logic       ds_spread;
    logic [7:0] merged_rev;
    logic [4:0] merged_rate;
    logic [3:0] merged_lanes;
    logic       merged_spread;

    modport owner (
        output local_rev, local_rate, local_lanes, local_spread,
        output ds_rev, ds_rate, ds_lanes, ds_spread,
        input  merged_rev, merged_rate, merged_lanes, merged_spread
    );
    modport merger (
        input  local_rev, local_rate, local_lanes, local_spread,
        input  ds_rev, ds_rate, ds_lanes, ds_spread,
        output merged_rev, merged_rate, merged_lanes, merged_spread
    );
endinterface
`default_nettype wire

/* File: cap_merge.sv */
// Combinational lowest-common capability merge.
// Assumes the owner registers the merged result.
`timescale 1ns/1ps
`default_nettype none
module cap_merge
    import branch_notify_pkg::*;
(
    cap_merge_if.merger m
);
    // Snap a rate to the largest legal code not above it; anything below 06h gives 06h
    function automatic logic [4:0] legal_rate(input logic [4:0] r);
        legal_rate = (r >= RATE_HIGH) ? RATE_HIGH : RATE_LOW;
    endfunction

    // Snap a lane count to the largest legal code not above it; 0 gives 1h
    function automatic logic [3:0] legal_lanes(input logic [3:0] l);
        if (l >= LANES_FOUR) begin
            legal_lanes = LANES_FOUR;
        end else if (l >= LANES_TWO) begin
            legal_lanes = LANES_TWO;
        end else begin
            legal_lanes = LANES_ONE;
        end
    endfunction

    // Lowest value common to both sides
    always_comb begin
        m.merged_rev = (m.ds_rev < m.local_rev) ?
                       m.ds_rev : m.local_rev;
        m.merged_rate = legal_rate((m.ds_rate < m.local_rate) ?
                                   m.ds_rate : m.local_rate);
        m.merged_lanes = legal_lanes((m.ds_lanes < m.local_lanes) ?
                                     m.ds_lanes : m.local_lanes);
        m.merged_spread = m.ds_spread & m.local_spread;
    end
endmodule
`default_nettype wire

/* File: branch_capability_hpd_notify.sv */
// Branch device capability bank, hot-plug notify pulse, identification
// request steering and repeater lane/symbol mirroring.
// Assumes all inputs other than pins come from logic on MCLK.
//
// Functional notes
// - On status change, drive hot-plug low 0.5-1 ms, then high again.
// - Without a local sink, forward identification requests downstream.
// - With several sinks, forward to the lowest-numbered occupied port.
// - Repeater supports four main-link lanes on both ports.
// - Downstream link copies upstream lane count, rate and spread.
// - Once both links configured, pass every symbol through unchanged.
// - Revision byte: minor in 3:0, major in 7:4; 1.0 is 10h.
// - Capability fields are the lowest common to device and downstream.
// - Lane rate field in bits 4:0, times 0.27 Gbps per lane.
// - Lane rate may be only 06h or 0Ah.
// - Lane total in bits 3:0; only 1h, 2h, 4h valid.
// - Reserved upper bits of rate, lane and spread bytes read zero.
// - Spread bit 0: 0 no spread, 1 half percent down spread.
// - Converters may use fewer lanes but enough for legacy bandwidth.
`timescale 1ns/1ps
`default_nettype none
module branch_capability_hpd_notify
    import branch_notify_pkg::*;
(
    input  wire logic                    MCLK,
    input  wire logic                    SYS_RST,
    // Register port from the sideband channel
    input  wire logic                    REG_RD,
    input  wire logic                    REG_WR,
    input  wire logic [7:0]              REG_ADDR,
    input  wire logic [7:0]              REG_WDATA,
    output logic      [7:0]              REG_RDATA,
    output logic                         REG_RVALID,
    // Status change events
    input  wire logic                    LINK_STATUS_CHANGE,
    input  wire logic                    DEVICE_STATUS_CHANGE,
    output logic                         HPD_OUT,
    // Downstream capability, after it was read
    input  wire logic                    DS_CAP_VALID,
    input  wire logic [7:0]              DS_REV,
    input  wire logic [4:0]              DS_RATE,
    input  wire logic [3:0]              DS_LANES,
    input  wire logic                    DS_SPREAD,
    // Identification data request steering
    input  wire logic                    LOCAL_SINK,
    input  wire logic [NUM_DS_PORTS-1:0] DS_SINK_PRESENT,
    input  wire logic                    ID_REQ,
    output logic                         ID_FWD,
    output logic      [NUM_DS_PORTS-1:0] ID_PORT_SEL,
    output logic                         ID_LOCAL,
    // Upstream link configuration and mirrored downstream setup
    input  wire logic                    UP_CFG_VALID,
    input  wire logic [3:0]              UP_LANES,
    input  wire logic [4:0]              UP_RATE,
    input  wire logic                    UP_SPREAD,
    input  wire logic                    DS_TRAINED,
    output logic      [3:0]              DS_CFG_LANES,
    output logic      [4:0]              DS_CFG_RATE,
    output logic                         DS_CFG_SPREAD,
    output logic                         DS_CFG_VALID,
    // Symbol pass-through, four lanes
    input  wire logic [LANES_MAX*SYMBOL_W-1:0] UP_SYMBOLS,
    input  wire logic                    UP_SYM_VALID,
    output logic      [LANES_MAX*SYMBOL_W-1:0] DS_SYMBOLS,
    output logic                         DS_SYM_VALID
);

    cap_merge_if cap_bus ();

    logic [7:0]          cap_rev;
    logic [4:0]          cap_rate;
    logic [3:0]          cap_lanes;
    logic                cap_spread;
    logic                cap_changed;
    hpd_state_type       hpd_state;
    logic [HPD_CNT_W-1:0] hpd_count;
    logic                pending;
    logic [NUM_DS_PORTS-1:0] next_port_sel;

    // Lowest-set-bit pick for request steering
    function automatic logic [NUM_DS_PORTS-1:0]
        lowest_port(input logic [NUM_DS_PORTS-1:0] present);
        lowest_port = present & (~present + 1'b1);
    endfunction

    // Feed the merge unit; local side is this device's own ceiling
    assign cap_bus.local_rev    = RST_CAPABILITY_REVISION;
    assign cap_bus.local_rate   = RST_PEAK_LANE_RATE;
    assign cap_bus.local_lanes  = RST_PEAK_LANE_TOTAL;
    assign cap_bus.local_spread = RST_SPREAD_SUPPORT;
    assign cap_bus.ds_rev       = DS_REV;
    assign cap_bus.ds_rate      = DS_RATE;
    assign cap_bus.ds_lanes     = DS_LANES;
    assign cap_bus.ds_spread    = DS_SPREAD;

    cap_merge u_merge (
        .m (cap_bus.merger)
    );

    // Capability bank: updated only from downstream reads, never by writes
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            cap_rev     <= RST_CAPABILITY_REVISION;
            cap_rate    <= RST_PEAK_LANE_RATE;
            cap_lanes   <= RST_PEAK_LANE_TOTAL;
            cap_spread  <= RST_SPREAD_SUPPORT;
            cap_changed <= 1'b0;
        end else begin
            cap_changed <= 1'b0;
            if (DS_CAP_VALID) begin
                cap_rev    <= cap_bus.merged_rev;
                cap_rate   <= cap_bus.merged_rate;
                cap_lanes  <= cap_bus.merged_lanes;
                cap_spread <= cap_bus.merged_spread;
                cap_changed <= (cap_bus.merged_rev != cap_rev) ||
                               (cap_bus.merged_rate != cap_rate) ||
                               (cap_bus.merged_lanes != cap_lanes) ||
                               (cap_bus.merged_spread != cap_spread);
            end
        end
    end

    // Register reads; writes have no effect on any byte
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD & ~REG_WR;
            if (REG_RD) begin
                case (REG_ADDR)
                    OFF_CAPABILITY_REVISION: REG_RDATA <= cap_rev;
                    OFF_PEAK_LANE_RATE:
                        REG_RDATA <= {3'h0, cap_rate};
                    OFF_PEAK_LANE_TOTAL:
                        REG_RDATA <= {4'h0, cap_lanes};
                    OFF_SPREAD_SUPPORT:
                        REG_RDATA <= {7'h00, cap_spread};
                    default:                 REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Events during a pulse are held so none is lost; set beats clear
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pending <= 1'b0;
        end else if (LINK_STATUS_CHANGE || DEVICE_STATUS_CHANGE ||
                     cap_changed) begin
            pending <= 1'b1;
        end else if (hpd_state == HPD_HIGH) begin
            pending <= 1'b0;
        end
    end

    // Hot-plug pulse: low for a fixed time mid-window, then high
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            hpd_state <= HPD_HIGH;
            hpd_count <= '0;
            HPD_OUT   <= 1'b1;
        end else begin
            case (hpd_state)
                HPD_HIGH: begin
                    HPD_OUT <= 1'b1;
                    if (pending) begin
                        hpd_state <= HPD_LOW;
                        hpd_count <= HPD_CNT_W'(HPD_LOW_CYCLES - 1);
                        HPD_OUT   <= 1'b0;
                    end
                end
                HPD_LOW: begin
                    HPD_OUT <= 1'b0;
                    if (hpd_count == '0) begin
                        hpd_state <= HPD_HOLD;
                        HPD_OUT   <= 1'b1;
                    end else begin
                        hpd_count <= hpd_count - 1'b1;
                    end
                end
                HPD_HOLD: begin
                    // One extra high cycle, two with HPD_HIGH, so a back-to-back event still shows
                    HPD_OUT   <= 1'b1;
                    hpd_state <= HPD_HIGH;
                end
                default: begin
                    hpd_state <= HPD_HIGH;
                    HPD_OUT   <= 1'b1;
                end
            endcase
        end
    end

    // Identification request steering
    assign next_port_sel = lowest_port(DS_SINK_PRESENT);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ID_FWD      <= 1'b0;
            ID_LOCAL    <= 1'b0;
            ID_PORT_SEL <= '0;
        end else begin
            ID_LOCAL <= ID_REQ & LOCAL_SINK;
            ID_FWD   <= ID_REQ & ~LOCAL_SINK & (|DS_SINK_PRESENT);
            if (ID_REQ && !LOCAL_SINK) begin
                ID_PORT_SEL <= next_port_sel;
            end else if (ID_REQ) begin
                ID_PORT_SEL <= '0;
            end
        end
    end

    // Downstream setup mirrors the upstream configuration
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DS_CFG_LANES  <= 4'h0;
            DS_CFG_RATE   <= 5'h00;
            DS_CFG_SPREAD <= 1'b0;
            DS_CFG_VALID  <= 1'b0;
        end else begin
            DS_CFG_VALID <= UP_CFG_VALID;
            if (UP_CFG_VALID) begin
                DS_CFG_LANES  <= UP_LANES;
                DS_CFG_RATE   <= UP_RATE;
                DS_CFG_SPREAD <= UP_SPREAD;
            end
        end
    end

    // Symbol pass-through; one register stage, no symbol is altered
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DS_SYMBOLS   <= '0;
            DS_SYM_VALID <= 1'b0;
        end else begin
            DS_SYM_VALID <= UP_SYM_VALID & UP_CFG_VALID & DS_TRAINED;
            DS_SYMBOLS   <= UP_SYMBOLS;
        end
    end

endmodule
`default_nettype wire

/* File: branch_notify_checker.sv */
// Assertions for the capability bank and hot-plug notify block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module branch_notify_checker
    import branch_notify_pkg::*;
(
    input wire logic                    MCLK,
    input wire logic                    SYS_RST,
    input wire logic                    REG_RD,
    input wire logic                    REG_WR,
    input wire logic [7:0]              REG_ADDR,
    input wire logic [7:0]              REG_RDATA,
    input wire logic                    REG_RVALID,
    input wire logic                    LINK_STATUS_CHANGE,
    input wire logic                    DEVICE_STATUS_CHANGE,
    input wire logic                    HPD_OUT,
    input wire logic                    LOCAL_SINK,
    input wire logic [NUM_DS_PORTS-1:0] DS_SINK_PRESENT,
    input wire logic                    ID_REQ,
    input wire logic                    ID_FWD,
    input wire logic                    ID_LOCAL,
    input wire logic [NUM_DS_PORTS-1:0] ID_PORT_SEL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic [16:0] low_cnt;
    // Low time of the notify line; a repetition would be far too long
    always_ff @(posedge MCLK) begin
        if (SYS_RST || HPD_OUT)
            low_cnt <= 17'h00000;
        else
            low_cnt <= low_cnt + 17'h00001;
    end
    a_hpd_width:
        assert property ($rose(HPD_OUT) |->
            low_cnt >= 17'h0C350 && low_cnt <= 17'h186A0)
        else $error("notify low time out of range");
    a_hpd_start:
        assert property (LINK_STATUS_CHANGE || DEVICE_STATUS_CHANGE
            |-> ##[1:8] !HPD_OUT) else $error("no notify pulse");
    a_write_inert:
        assert property (REG_WR |=> !REG_RVALID)
        else $error("write produced an answer");
    a_rev_ceiling:
        assert property (REG_RVALID && $past(REG_ADDR) == 8'h00
            |-> REG_RDATA <= 8'h10) else $error("revision above local");
    a_rate_codes:
        assert property (REG_RVALID && $past(REG_ADDR) == 8'h01
            |-> REG_RDATA inside {8'h06, 8'h0A}) else $error("bad rate");
    a_lane_codes:
        assert property (REG_RVALID && $past(REG_ADDR) == 8'h02
            |-> REG_RDATA inside {8'h01, 8'h02, 8'h04})
        else $error("bad lane total");
    a_spread_bits:
        assert property (REG_RVALID && $past(REG_ADDR) == 8'h03
            |-> REG_RDATA[7:1] == 7'h00) else $error("spread bits set");
    a_id_local:
        assert property (ID_REQ && LOCAL_SINK |=> ID_LOCAL && !ID_FWD)
        else $error("local request forwarded");
    a_id_lowest:
        assert property (ID_REQ && !LOCAL_SINK && DS_SINK_PRESENT != 4'h0
            |=> ID_FWD && $onehot(ID_PORT_SEL)
            && (ID_PORT_SEL & $past(DS_SINK_PRESENT)) != 4'h0
            && ((ID_PORT_SEL - 4'h1) & $past(DS_SINK_PRESENT)) == 4'h0)
        else $error("bad port");
endmodule
bind branch_capability_hpd_notify branch_notify_checker chk_u (
    .MCLK, .SYS_RST, .REG_RD, .REG_WR, .REG_ADDR, .REG_RDATA, .REG_RVALID,
    .LINK_STATUS_CHANGE, .DEVICE_STATUS_CHANGE, .HPD_OUT, .LOCAL_SINK,
    .DS_SINK_PRESENT, .ID_REQ, .ID_FWD, .ID_LOCAL, .ID_PORT_SEL
);
`default_nettype wire

/* File: branch_source_model.sv */
// Upstream source model: fetches the capability bytes after a re-plug.
// Assumes reads take one strobe cycle each and may run back to back.
`timescale 1ns/1ps
`default_nettype none
module branch_source_model (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       hpd_in,
    output logic            rd,
    output logic      [7:0] addr
);
    logic hpd_q;
    // Status bytes sit outside this block, so only capabilities are read
    always_ff @(posedge mclk) begin
        hpd_q <= hpd_in;
        if (sys_rst) begin
            rd <= 1'b0;
            addr <= 8'h00;
        end else if (hpd_in && !hpd_q) begin
            rd <= 1'b1;
            addr <= 8'h00;
        end else if (rd && addr != 8'h03) begin
            addr <= addr + 8'h01;
        end else begin
            rd <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: branch_capability_hpd_notify_tb_top.sv */
// Self-checking bench for the capability bank and hot-plug notify block.
// Assumes the source model owns the register port after a re-plug.
`timescale 1ns/1ps
`default_nettype none
module branch_capability_hpd_notify_tb_top import branch_notify_pkg::*;;
    logic        MCLK, SYS_RST, b_rd, b_wr, s_rd, LINK_STATUS_CHANGE,
                 DEVICE_STATUS_CHANGE, DS_CAP_VALID, DS_SPREAD, LOCAL_SINK,
                 ID_REQ, UP_CFG_VALID, UP_SPREAD, DS_TRAINED, UP_SYM_VALID,
                 REG_RVALID, HPD_OUT, ID_FWD, ID_LOCAL, DS_CFG_SPREAD,
                 DS_CFG_VALID, DS_SYM_VALID, l, v, t;
    logic [3:0]  DS_LANES, DS_SINK_PRESENT, UP_LANES, ID_PORT_SEL,
                 DS_CFG_LANES, p, e;
    logic [4:0]  DS_RATE, UP_RATE, DS_CFG_RATE;
    logic [7:0]  b_addr, s_addr, REG_WDATA, DS_REV, REG_RDATA, cap [5];
    logic [35:0] UP_SYMBOLS, DS_SYMBOLS;
    logic [45:0] w;
    logic [47:0] rq[$], iq[$], sq[$];
    int          bad_count, comparisons, n;
    wire logic        REG_RD = b_rd | s_rd;
    wire logic        REG_WR = b_wr;
    wire logic [7:0]  REG_ADDR = s_rd ? s_addr : b_addr;
    wire logic [47:0] id_seen = {42'h0, ID_LOCAL, ID_FWD,
                                 ID_PORT_SEL & {4{ID_FWD}}};
    wire logic [47:0] sym_seen = {1'b0, DS_CFG_VALID, DS_CFG_LANES,
                                  DS_CFG_RATE, DS_CFG_SPREAD, DS_SYMBOLS};
    branch_capability_hpd_notify dut_u (.MCLK, .SYS_RST, .REG_RD, .REG_WR,
        .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID, .LINK_STATUS_CHANGE,
        .DEVICE_STATUS_CHANGE, .HPD_OUT, .DS_CAP_VALID, .DS_REV, .DS_RATE,
        .DS_LANES, .DS_SPREAD, .LOCAL_SINK, .DS_SINK_PRESENT, .ID_REQ,
        .ID_FWD, .ID_PORT_SEL, .ID_LOCAL, .UP_CFG_VALID, .UP_LANES,
        .UP_RATE, .UP_SPREAD, .DS_TRAINED, .DS_CFG_LANES, .DS_CFG_RATE,
        .DS_CFG_SPREAD, .DS_CFG_VALID, .UP_SYMBOLS, .UP_SYM_VALID,
        .DS_SYMBOLS, .DS_SYM_VALID);
    branch_source_model src_u (.mclk(MCLK), .sys_rst(SYS_RST),
        .hpd_in(HPD_OUT), .rd(s_rd), .addr(s_addr));
    always #5 MCLK = ~MCLK;
    task automatic chk(input logic [47:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One register cycle; a plain read leaves a note for the watcher
    task automatic bus(input logic r, wr, input logic [7:0] a);
        b_rd <= r;
        b_wr <= wr;
        b_addr <= a;
        REG_WDATA <= 8'($urandom);
        if (r && !wr)
            rq.push_back({40'h0, cap[a]});
        @(posedge MCLK);
    endtask
    // Bounded wait for the notify line to reach a level
    task automatic wait_hpd(input logic lv, input int lim);
        for (n = 0; n < lim && HPD_OUT !== lv; n++)
            @(posedge MCLK);
    endtask
    // Watcher: each result takes the oldest note of its kind
    always @(posedge MCLK) begin
        if (REG_RVALID === 1'b1)
            chk(REG_RDATA, rq.pop_front());
        if ((ID_FWD | ID_LOCAL) === 1'b1)
            chk(id_seen, iq.pop_front());
        if (DS_SYM_VALID === 1'b1)
            chk(sym_seen, sq.pop_front());
    end
    // Watchdog sized well above the one long notify pulse
    initial begin
        repeat (90000) @(posedge MCLK);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        void'($urandom(86464));
        {MCLK, b_rd, b_wr, b_addr, REG_WDATA, LINK_STATUS_CHANGE,
         DEVICE_STATUS_CHANGE, DS_CAP_VALID, DS_REV, DS_RATE, DS_LANES,
         DS_SPREAD, LOCAL_SINK, DS_SINK_PRESENT, ID_REQ, UP_CFG_VALID,
         UP_LANES, UP_RATE, UP_SPREAD, DS_TRAINED, UP_SYMBOLS,
         UP_SYM_VALID} = '0;
        SYS_RST = 1'b1;
        repeat (10) @(posedge MCLK);
        SYS_RST <= 1'b0;
        // Idle levels straight out of reset: line high, no pulses
        chk(48'({HPD_OUT, REG_RVALID, ID_FWD, ID_LOCAL, DS_CFG_VALID,
                 DS_SYM_VALID}), 48'h20);
        cap = '{RST_CAPABILITY_REVISION, {3'h0, RST_PEAK_LANE_RATE},
                {4'h0, RST_PEAK_LANE_TOTAL}, {7'h0, RST_SPREAD_SUPPORT},
                8'h00};
        // Reset contents and an unmapped byte, then writes that must not land
        for (int i = 0; i < 5; i++)
            bus(1'b1, 1'b0, 8'(i));
        bus(1'b0, 1'b1, OFF_PEAK_LANE_RATE);
        bus(1'b1, 1'b1, OFF_PEAK_LANE_TOTAL);
        bus(1'b1, 1'b0, OFF_PEAK_LANE_RATE);
        bus(1'b0, 1'b0, 8'h00);
        $display("test registers done");
        // Back-to-back identification requests over random sink maps
        repeat (16) begin
            l = ($urandom % 3) == 0;
            p = 4'($urandom);
            e = 4'h0;
            // Highest port first, so the lowest occupied one is left
            for (int k = 3; k >= 0; k--)
                if (p[k])
                    e = 4'h1 << k;
            LOCAL_SINK <= l;
            DS_SINK_PRESENT <= p;
            ID_REQ <= 1'b1;
            // With no sink anywhere nothing may answer
            if (l || p != 4'h0)
                iq.push_back(l ? 48'h20 : {42'h0, 2'b01, e});
            @(posedge MCLK);
        end
        ID_REQ <= 1'b0;
        // Mirrored setup and symbols while training comes and goes
        UP_CFG_VALID <= 1'b1;
        repeat (24) begin
            w = {4'h1 << ($urandom % 3),
                 (($urandom % 2) ? RATE_HIGH : RATE_LOW),
                 1'($urandom), 36'({$urandom, $urandom})};
            {v, t} = 2'($urandom);
            {UP_LANES, UP_RATE, UP_SPREAD, UP_SYMBOLS} <= w;
            UP_SYM_VALID <= v;
            DS_TRAINED <= t;
            if (v && t)
                sq.push_back({2'b01, w});
            @(posedge MCLK);
        end
        UP_SYM_VALID <= 1'b0;
        repeat (2) @(posedge MCLK);
        $display("test id and stream done");
        // Status event, then a capability drop and an event during the pulse
        LINK_STATUS_CHANGE <= 1'b1;
        @(posedge MCLK);
        LINK_STATUS_CHANGE <= 1'b0;
        DS_CAP_VALID <= 1'b1;
        {DS_REV, DS_RATE, DS_LANES, DS_SPREAD} <=
            {8'h10, RATE_LOW, LANES_TWO, 1'b0};
        @(posedge MCLK);
        DS_CAP_VALID <= 1'b0;
        DEVICE_STATUS_CHANGE <= 1'b1;
        cap[1] = 8'h06;
        cap[2] = 8'h02;
        cap[3] = 8'h00;
        wait_hpd(1'b0, 6);
        chk(HPD_OUT, 1'b0);
        DEVICE_STATUS_CHANGE <= 1'b0;
        bus(1'b1, 1'b0, OFF_PEAK_LANE_TOTAL);
        bus(1'b0, 1'b0, 8'h00);
        for (int i = 0; i < 4; i++)
            rq.push_back({40'h0, cap[i]});
        wait_hpd(1'b1, 80000);
        // Counting starts three edges into the pulse and ends one edge late
        chk({47'h0, n >= HPD_LOW_MIN_US * 1000 / CLK_PERIOD_NS - 2},
            48'h1);
        chk(HPD_OUT, 1'b1);
        wait_hpd(1'b0, 12);
        chk(HPD_OUT, 1'b0);
        repeat (6) @(posedge MCLK);
        chk(48'(rq.size() + iq.size() + sq.size()), 48'h0);
        $display("test hot-plug done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
